// File: dma_engine.sv
module dma_engine (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic [127:0] trigger_in,
  output logic              mem_req,
  output logic              mem_we,
  output logic [15:0]       mem_addr,
  output logic [1:0]        mem_be,
  output logic [15:0]       mem_wdata,
  input  wire logic         mem_gnt,
  input  wire logic [15:0]  mem_rdata,
  output logic              irq
);

  typedef struct packed {
    logic                                 engine_enable;
    logic                                 prio_rr;
    logic [15:0]                          upper;
    logic [15:0]                          lower;
    logic [15:0]                          dbuf;
    logic [5:0][dma_engine_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [5:0][6:0]                      trig;
    logic [5:0][4:0]                      flags;
    logic [5:0]                           halfen;
    logic [5:0][15:0]                     src;
    logic [5:0][15:0]                     dst;
    logic [5:0][15:0]                     cnt;
    logic [5:0][15:0]                     src0;
    logic [5:0][15:0]                     dst0;
    logic [5:0][15:0]                     cnt0;
    logic [5:0]                           pending;
    logic [5:0]                           irq_status;
    logic [5:0]                           irq_enable;
    dma_engine_pkg::xfer_state_t          state;
    logic [2:0]                           active;
    logic [2:0]                           last;
    logic                                 mem_req;
    logic                                 mem_we;
    logic [15:0]                          mem_addr;
    logic [1:0]                           mem_be;
    logic [15:0]                          mem_wdata;
    logic [31:0]                          prdata;
  } regs_t;

  regs_t r;
  regs_t next_r;

  function automatic logic [2:0] pick(input logic [5:0] req,
                                      input logic [2:0] start);
    logic [2:0] idx;
    logic       found;
    pick  = start;
    found = 1'b0;
    for (int i = 0; i < dma_engine_pkg::NUM_CH; i++) begin
      idx = 3'((int'(start) + i) % dma_engine_pkg::NUM_CH);
      if (!found && req[idx]) begin
        pick  = idx;
        found = 1'b1;
      end
    end
  endfunction

  // Limit check: only data RAM above register space is guarded
  function automatic logic [1:0] limit_viol(input logic [15:0] a,
                                            input logic [15:0] hi,
                                            input logic [15:0] lo);
    limit_viol[1] = (a > dma_engine_pkg::SFR_TOP) && (a > hi);
    limit_viol[0] = (a > dma_engine_pkg::SFR_TOP) && (a < lo);
  endfunction

  function automatic logic [15:0] step_ptr(input logic [15:0] p,
                                           input logic [1:0]  mode,
                                           input logic        byte_sz);
    logic [15:0] step;
    step = byte_sz ? dma_engine_pkg::STEP_BYTE : dma_engine_pkg::STEP_WORD;
    case (mode)
      dma_engine_pkg::AMODE_INC: step_ptr = 16'(p + step);
      dma_engine_pkg::AMODE_DEC: step_ptr = 16'(p - step);
      default:                   step_ptr = p;
    endcase
  endfunction

  logic        wr_en;
  logic        rd_setup;
  logic        in_ch;
  logic [2:0]  ch_sel;
  logic [4:0]  ch_ofs;
  logic        mapped;
  logic [31:0] rd_val;
  logic [5:0]  hit;
  logic [5:0]  elig;
  logic [1:0]  viol;
  logic [15:0] new_cnt;
  logic [2:0]  a;
  logic [15:0] wd;

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign in_ch    = (paddr[11:8] == 4'h0) && (paddr[7:5] != 3'h0)
                    && (paddr[7:5] <= 3'h6) && (paddr[1:0] == 2'h0);
  assign ch_sel   = 3'(paddr[7:5] - 3'h1);
  assign ch_ofs   = paddr[4:0];
  assign a        = r.active;
  assign wd       = pwdata[15:0];

  always_comb begin
    mapped = 1'b0;
    rd_val = 32'h0000_0000;
    if (in_ch) begin
      mapped = 1'b1;
      case (ch_ofs)
        dma_engine_pkg::OFS_CH_CONTROL:
          rd_val = {22'h00_0000, r.ctrl[ch_sel]};
        dma_engine_pkg::OFS_CH_INTERRUPT:
          rd_val = {17'h0_0000, r.trig[ch_sel], r.flags[ch_sel],
                    2'h0, r.halfen[ch_sel]};
        dma_engine_pkg::OFS_CH_SOURCE: rd_val = {16'h0000, r.src[ch_sel]};
        dma_engine_pkg::OFS_CH_DEST:   rd_val = {16'h0000, r.dst[ch_sel]};
        dma_engine_pkg::OFS_CH_COUNT:  rd_val = {16'h0000, r.cnt[ch_sel]};
        default:                       mapped = 1'b0;
      endcase
    end else if (paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0) begin
      mapped = 1'b1;
      case (paddr[7:0])
        dma_engine_pkg::OFS_ENGINE_CONTROL:
          rd_val = {16'h0000, r.engine_enable, 14'h0000, r.prio_rr};
        dma_engine_pkg::OFS_UPPER_LIMIT: rd_val = {16'h0000, r.upper};
        dma_engine_pkg::OFS_LOWER_LIMIT: rd_val = {16'h0000, r.lower};
        dma_engine_pkg::OFS_DATA_BUFFER: rd_val = {16'h0000, r.dbuf};
        dma_engine_pkg::OFS_IRQ_STATUS:  rd_val = {26'h000_0000, r.irq_status};
        dma_engine_pkg::OFS_IRQ_CLEAR:   rd_val = 32'h0000_0000;
        dma_engine_pkg::OFS_IRQ_ENABLE:  rd_val = {26'h000_0000, r.irq_enable};
        default:                         mapped = 1'b0;
      endcase
    end
  end

  // Trigger hits; a disabled channel ignores its source
  for (genvar n = 0; n < dma_engine_pkg::NUM_CH; n++) begin : g_hit
    assign hit[n] = r.ctrl[n][dma_engine_pkg::CHANNEL_ENABLE_BIT]
                    && (r.trig[n] != dma_engine_pkg::TRIG_OFF)
                    && trigger_in[r.trig[n]];
  end

  always_comb begin
    next_r  = r;
    elig    = r.pending;
    viol    = 2'h0;
    new_cnt = 16'(r.cnt[a] - 16'h0001);
    if (rd_setup) begin
      next_r.prdata = rd_val;
    end
    // Software writes first so hardware set wins below
    if (wr_en && in_ch) begin
      case (ch_ofs)
        dma_engine_pkg::OFS_CH_CONTROL: begin
          next_r.ctrl[ch_sel] = wd[dma_engine_pkg::CTRL_WIDTH-1:0];
          if (wd[dma_engine_pkg::SW_REQUEST_BIT]) begin
            next_r.pending[ch_sel] = 1'b1;
          end
        end
        dma_engine_pkg::OFS_CH_INTERRUPT: begin
          next_r.trig[ch_sel]   = wd[dma_engine_pkg::TRIG_LSB +: 7];
          next_r.flags[ch_sel]  = wd[dma_engine_pkg::FLAG_LSB +: 5];
          next_r.halfen[ch_sel] = wd[dma_engine_pkg::HALFEN_BIT];
        end
        dma_engine_pkg::OFS_CH_SOURCE: begin
          next_r.src[ch_sel]  = wd;
          next_r.src0[ch_sel] = wd;
        end
        dma_engine_pkg::OFS_CH_DEST: begin
          next_r.dst[ch_sel]  = wd;
          next_r.dst0[ch_sel] = wd;
        end
        dma_engine_pkg::OFS_CH_COUNT: begin
          next_r.cnt[ch_sel]  = wd;
          next_r.cnt0[ch_sel] = wd;
        end
        default: ;
      endcase
    end else if (wr_en) begin
      case (paddr[7:0])
        dma_engine_pkg::OFS_ENGINE_CONTROL: begin
          next_r.engine_enable =
            wd[dma_engine_pkg::ENGINE_ENABLE_BIT];
          next_r.prio_rr = wd[dma_engine_pkg::PRIORITY_SCHEME_BIT];
        end
        dma_engine_pkg::OFS_UPPER_LIMIT: next_r.upper = wd;
        dma_engine_pkg::OFS_LOWER_LIMIT: next_r.lower = wd;
        dma_engine_pkg::OFS_DATA_BUFFER: next_r.dbuf  = wd;
        dma_engine_pkg::OFS_IRQ_CLEAR:
          next_r.irq_status = r.irq_status & ~pwdata[5:0];
        dma_engine_pkg::OFS_IRQ_ENABLE: next_r.irq_enable = pwdata[5:0];
        default: ;
      endcase
    end
    // A trigger on a busy channel is an overrun
    for (int n = 0; n < dma_engine_pkg::NUM_CH; n++) begin
      if (hit[n]) begin
        if (r.pending[n]) begin
          next_r.flags[n][dma_engine_pkg::F_OVERRUN] = 1'b1;
        end
        next_r.pending[n] = 1'b1;
      end
    end
    // Fixed scheme: the channel just served steps aside for a later one
    if (r.pending[r.last] && ((r.pending >> r.last) >> 1) != 6'h00) begin
      elig[r.last] = 1'b0;
    end
    case (r.state)
      dma_engine_pkg::ST_IDLE: begin
        if (r.pending != 6'h00) begin
          next_r.active = r.prio_rr
            ? pick(r.pending, (r.last == 3'h5) ? 3'h0 : 3'(r.last + 3'h1))
            : pick(elig, 3'h0);
          next_r.state = dma_engine_pkg::ST_RD_ISSUE;
        end
      end
      dma_engine_pkg::ST_RD_ISSUE, dma_engine_pkg::ST_WR_ISSUE: begin
        viol = limit_viol((r.state == dma_engine_pkg::ST_RD_ISSUE)
                          ? r.src[a] : r.dst[a], r.upper, r.lower);
        if (viol != 2'h0) begin
          // Offending access never reaches the bus
          next_r.flags[a][dma_engine_pkg::F_HIGH] = viol[1];
          next_r.flags[a][dma_engine_pkg::F_LOW]  = viol[0];
          next_r.pending[a] = 1'b0;
          next_r.ctrl[a][dma_engine_pkg::SW_REQUEST_BIT] = 1'b0;
          next_r.irq_status[a] = 1'b1;
          next_r.last  = a;
          next_r.state = dma_engine_pkg::ST_IDLE;
        end else begin
          next_r.mem_req = 1'b1;
          next_r.mem_we  = (r.state == dma_engine_pkg::ST_WR_ISSUE);
          next_r.mem_addr = next_r.mem_we ? r.dst[a] : r.src[a];
          next_r.mem_be  = 2'h3;
          next_r.mem_wdata = r.dbuf;
          if (r.ctrl[a][dma_engine_pkg::SIZE_BIT]) begin
            next_r.mem_be = next_r.mem_addr[0] ? 2'h2 : 2'h1;
            next_r.mem_wdata = {r.dbuf[7:0], r.dbuf[7:0]};
          end
          next_r.state = next_r.mem_we ? dma_engine_pkg::ST_WR_WAIT
                                       : dma_engine_pkg::ST_RD_WAIT;
        end
      end
      dma_engine_pkg::ST_RD_WAIT: begin
        if (mem_gnt) begin
          next_r.mem_req = 1'b0;
          next_r.dbuf = mem_rdata;
          if (r.ctrl[a][dma_engine_pkg::SIZE_BIT]) begin
            next_r.dbuf = {8'h00, r.mem_addr[0] ? mem_rdata[15:8]
                                                : mem_rdata[7:0]};
          end
          next_r.state = dma_engine_pkg::ST_WR_ISSUE;
        end
      end
      dma_engine_pkg::ST_WR_WAIT: begin
        if (mem_gnt) begin
          next_r.mem_req = 1'b0;
          next_r.last  = a;
          next_r.state = dma_engine_pkg::ST_IDLE;
          next_r.cnt[a] = new_cnt;
          next_r.src[a] = step_ptr(r.src[a], r.ctrl[a][dma_engine_pkg::
                          SOURCE_ADDRESS_MODE_LSB +: 2], r.ctrl[a][1]);
          next_r.dst[a] = step_ptr(r.dst[a], r.ctrl[a][dma_engine_pkg::
                          DESTINATION_ADDRESS_MODE_LSB +: 2], r.ctrl[a][1]);
          if (r.halfen[a] && new_cnt == (r.cnt0[a] >> 1)) begin
            next_r.flags[a][dma_engine_pkg::F_HALF] = 1'b1;
            next_r.irq_status[a] = 1'b1;
          end
          // One-shot stops after one item, continuous runs to zero
          if (!r.ctrl[a][dma_engine_pkg::TRANSFER_MODE_SELECT_LSB
                          + dma_engine_pkg::TRANSFER_MODE_SELECT_CONT_BIT]
              || new_cnt == 16'h0000) begin
            next_r.pending[a] = hit[a];
            next_r.ctrl[a][dma_engine_pkg::SW_REQUEST_BIT] = 1'b0;
          end
          if (new_cnt == 16'h0000) begin
            next_r.flags[a][dma_engine_pkg::F_DONE] = 1'b1;
            next_r.irq_status[a] = 1'b1;
            if (r.ctrl[a][dma_engine_pkg::RELOAD_BIT]
                || r.ctrl[a][dma_engine_pkg::TRANSFER_MODE_SELECT_LSB
                             + dma_engine_pkg::TRANSFER_MODE_SELECT_REPEAT_BIT]) begin
              next_r.src[a] = r.src0[a];
              next_r.dst[a] = r.dst0[a];
              next_r.cnt[a] = r.cnt0[a];
            end
            if (!r.ctrl[a][dma_engine_pkg::TRANSFER_MODE_SELECT_LSB
                           + dma_engine_pkg::TRANSFER_MODE_SELECT_REPEAT_BIT]) begin
              next_r.ctrl[a][dma_engine_pkg::CHANNEL_ENABLE_BIT] = 1'b0;
              next_r.pending[a] = 1'b0;
            end
          end
        end
      end
      default: next_r.state = dma_engine_pkg::ST_IDLE;
    endcase
    for (int n = 0; n < dma_engine_pkg::NUM_CH; n++) begin
      if (next_r.flags[n] != r.flags[n] && hit[n] && r.pending[n]) begin
        next_r.irq_status[n] = 1'b1;
      end
    end
    // Disabled engine forces idle, clears pending and drops mem_req; a grant in flight still updates its channel
    if (!r.engine_enable) begin
      next_r.state   = dma_engine_pkg::ST_IDLE;
      next_r.pending = 6'h00;
      next_r.mem_req = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r       <= '0;
      r.state <= dma_engine_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign prdata    = r.prdata;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;
  assign mem_req   = r.mem_req;
  assign mem_we    = r.mem_we;
  assign mem_addr  = r.mem_addr;
  assign mem_be    = r.mem_be;
  assign mem_wdata = r.mem_wdata;
  assign irq       = |(r.irq_status & r.irq_enable);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Either issue phase may hit a limit
  logic viol_now;
  assign viol_now = r.engine_enable
    && ((r.state == dma_engine_pkg::ST_RD_ISSUE
         && limit_viol(r.src[a], r.upper, r.lower) != 2'h0)
        || (r.state == dma_engine_pkg::ST_WR_ISSUE
            && limit_viol(r.dst[a], r.upper, r.lower) != 2'h0));

  property p_disable_stops;
    !r.engine_enable |=> !mem_req && r.state == dma_engine_pkg::ST_IDLE;
  endproperty
  a_disable_stops: assert property (p_disable_stops)
    else $error("engine disabled but bus still busy");

  property p_rr_next;
    r.state == dma_engine_pkg::ST_IDLE && r.engine_enable && r.prio_rr
      && r.pending[1] && r.last == 3'h0 |=> r.active == 3'h1;
  endproperty
  a_rr_next: assert property (p_rr_next)
    else $error("round robin did not rotate");

  property p_fixed_low;
    r.state == dma_engine_pkg::ST_IDLE && r.engine_enable && !r.prio_rr
      && r.pending[0] && r.last != 3'h0 |=> r.active == 3'h0;
  endproperty
  a_fixed_low: assert property (p_fixed_low)
    else $error("fixed priority skipped channel 0");

  property p_viol_no_bus;
    viol_now |=> !mem_req ##1 !mem_req;
  endproperty
  a_viol_no_bus: assert property (p_viol_no_bus)
    else $error("out of limit access reached the bus");

  property p_viol_flag;
    viol_now
      |=> (r.flags[$past(a)][dma_engine_pkg::F_HIGH]
           || r.flags[$past(a)][dma_engine_pkg::F_LOW])
          && r.irq_status[$past(a)];
  endproperty
  a_viol_flag: assert property (p_viol_flag)
    else $error("limit violation not flagged");

  property p_byte_lane;
    mem_req && r.ctrl[a][dma_engine_pkg::SIZE_BIT]
      |-> mem_be == (mem_addr[0] ? 2'h2 : 2'h1);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte lane does not follow address bit 0");

  property p_hold_src;
    r.state == dma_engine_pkg::ST_WR_WAIT && mem_gnt && r.engine_enable
      && r.ctrl[a][dma_engine_pkg::SOURCE_ADDRESS_MODE_LSB +: 2] == dma_engine_pkg::AMODE_HOLD
      && r.cnt[a] != 16'h0001
      |=> r.src[$past(a)] == $past(r.src[a]);
  endproperty
  a_hold_src: assert property (p_hold_src)
    else $error("held source pointer moved");

  property p_reload;
    r.state == dma_engine_pkg::ST_WR_WAIT && mem_gnt && r.engine_enable
      && r.cnt[a] == 16'h0001
      && (r.ctrl[a][dma_engine_pkg::RELOAD_BIT]
          || r.ctrl[a][dma_engine_pkg::TRANSFER_MODE_SELECT_LSB
                       + dma_engine_pkg::TRANSFER_MODE_SELECT_REPEAT_BIT])
      |=> r.cnt[$past(a)] == $past(r.cnt0[a]);
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter not reloaded");

  property p_swreq_clear;
    r.state == dma_engine_pkg::ST_WR_WAIT && mem_gnt && r.engine_enable
      && r.cnt[a] == 16'h0001 && !(wr_en && in_ch)
      |=> !r.ctrl[$past(a)][dma_engine_pkg::SW_REQUEST_BIT];
  endproperty
  a_swreq_clear: assert property (p_swreq_clear)
    else $error("software request not cleared at completion");

  c_write_done: cover property (r.state == dma_engine_pkg::ST_WR_WAIT
                                && mem_gnt);
  c_violation: cover property (viol_now);
  c_irq: cover property (irq);

endmodule

// File: dma_engine_pkg.sv
package dma_engine_pkg;

  localparam int NUM_CH = 6;

  // Module-level register byte offsets
  localparam logic [7:0] OFS_ENGINE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_UPPER_LIMIT    = 8'h04;
  localparam logic [7:0] OFS_LOWER_LIMIT    = 8'h08;
  localparam logic [7:0] OFS_DATA_BUFFER    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR      = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE     = 8'h18;

  // Channel n occupies 0x20*(n+1) .. +0x1F
  localparam int         CH_INDEX_LSB       = 5;
  localparam logic [4:0] OFS_CH_CONTROL     = 5'h00;
  localparam logic [4:0] OFS_CH_INTERRUPT   = 5'h04;
  localparam logic [4:0] OFS_CH_SOURCE      = 5'h08;
  localparam logic [4:0] OFS_CH_DEST        = 5'h0C;
  localparam logic [4:0] OFS_CH_COUNT       = 5'h10;

  // Engine control register
  localparam int ENGINE_ENABLE_BIT   = 15;
  localparam int PRIORITY_SCHEME_BIT = 0;

  // Channel control register
  localparam int CTRL_WIDTH         = 10;
  localparam int CHANNEL_ENABLE_BIT = 0;
  localparam int SIZE_BIT           = 1;
  localparam int TRANSFER_MODE_SELECT_LSB         = 2;
  localparam int DESTINATION_ADDRESS_MODE_LSB         = 4;
  localparam int SOURCE_ADDRESS_MODE_LSB         = 6;
  localparam int SW_REQUEST_BIT     = 8;
  localparam int RELOAD_BIT         = 9;

  // Channel interrupt register
  localparam int TRIG_LSB   = 8;
  localparam int FLAG_LSB   = 3;
  localparam int HALFEN_BIT = 0;
  localparam int F_OVERRUN  = 0;
  localparam int F_HALF     = 1;
  localparam int F_DONE     = 2;
  localparam int F_LOW      = 3;
  localparam int F_HIGH     = 4;

  localparam logic [1:0] AMODE_HOLD = 2'h0;
  localparam logic [1:0] AMODE_INC  = 2'h1;
  localparam logic [1:0] AMODE_DEC  = 2'h2;
  localparam logic [1:0] AMODE_PIA  = 2'h3;
  localparam int TRANSFER_MODE_SELECT_REPEAT_BIT  = 0;
  localparam int TRANSFER_MODE_SELECT_CONT_BIT    = 1;
  localparam logic [6:0] TRIG_OFF   = 7'h00;

  localparam logic [15:0] SFR_TOP   = 16'h07FF;
  localparam logic [15:0] RESET_16  = 16'h0000;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_RD_ISSUE = 5'h02,
    ST_RD_WAIT  = 5'h04,
    ST_WR_ISSUE = 5'h08,
    ST_WR_WAIT  = 5'h10
  } xfer_state_t;

endpackage

// File: dma_memory_model.sv
module dma_memory_model (
  input  wire logic        core_clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [1:0]  mem_be,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_gnt,
  output logic [15:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [1:0]  lag = 2'h0;
  logic [1:0]  cnt = 2'h0;
  wire  [7:0]  idx = mem_addr[8:1];
  // Junk outside grant so a late sample is caught
  assign mem_rdata = mem_gnt ? mem[idx] : ~mem[idx];
  initial mem_gnt = 1'b0;
  // Grant delay cycles 0..3, one cycle longer each grant, then back to 0
  always @(posedge core_clk) begin
    mem_gnt <= 1'b0;
    if (mem_req && !mem_gnt) begin
      cnt <= cnt + 2'h1;
      if (cnt == lag) begin
        mem_gnt <= 1'b1;
        cnt <= 2'h0;
        lag <= lag + 2'h1;
      end
    end
    if (mem_gnt && mem_req && mem_we) begin
      if (mem_be[0]) mem[idx][7:0] <= mem_wdata[7:0];
      if (mem_be[1]) mem[idx][15:8] <= mem_wdata[15:8];
    end
  end
endmodule

// File: dma_engine_tb.sv
module dma_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } note_t;
  logic         core_clk = 1'b0;
  logic         reset = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [127:0] trigger_in = '0;
  logic [31:0]  prdata;
  logic         pready, pslverr, mem_req, mem_we, mem_gnt, irq;
  logic [15:0]  mem_addr, mem_wdata, mem_rdata, w0;
  logic [1:0]   mem_be;
  logic [6:0]   code;
  note_t        q[$];
  note_t        nt;
  int           n_fail = 0;
  int           n_tests = 0;
  int           seed = 82;
  int           busy;

  always #5 core_clk = ~core_clk;

  dma_engine u_dma_engine (.core_clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_in, .mem_req,
    .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_gnt, .mem_rdata, .irq);
  dma_memory_model u_dma_memory_model (.core_clk, .mem_req, .mem_we,
    .mem_addr, .mem_be, .mem_wdata, .mem_gnt, .mem_rdata);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Read results are judged where they appear
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      nt = q.pop_front();
      chk(prdata & nt.m, nt.d & nt.m);
      chk({31'h0, pslverr}, {31'h0, nt.e});
    end
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'hFFFF, input logic e = 1'b0);
    q.push_back('{d, m, e});
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [11:0] ch(input int n, input logic [4:0] o);
    return 12'(32 * (n + 1)) | {7'h0, o};
  endfunction

  task automatic prog(input int n, input logic [15:0] s, input logic [15:0] t,
                      input logic [15:0] c, input logic [15:0] ctl);
    apb(1'b1, ch(n, 5'h08), {16'h0, s});
    apb(1'b1, ch(n, 5'h0C), {16'h0, t});
    apb(1'b1, ch(n, 5'h10), {16'h0, c});
    apb(1'b1, ch(n, 5'h00), {16'h0, ctl});
  endtask

  // Done once the data bus has been idle for eight cycles
  task automatic await_done();
    int k;
    int quiet;
    k = 0;
    quiet = 0;
    while (quiet < 8) begin
      @(posedge core_clk);
      quiet = mem_req ? 0 : quiet + 1;
      k++;
      if (k > 500) begin
        n_fail++;
        tally_and_finish();
      end
    end
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(12'h000, 32'h0);
    rd(ch(0, 5'h00), 32'h0);
    apb(1'b1, 12'h000, 32'hFFFF);
    rd(12'h000, 32'h8001);
    apb(1'b1, 12'h000, 32'h8000);
    rd(12'h01C, 32'h0, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, 12'h004, 32'hFFFF);
    apb(1'b1, 12'h008, 32'h0800);
    rd(12'h008, 32'h0800);
    apb(1'b1, 12'h018, 32'h3F);
    $display("test registers done");
    w0 = 16'($random(seed));
    u_dma_memory_model.mem[8'h80] = w0;
    u_dma_memory_model.mem[8'h81] = ~w0;
    prog(0, 16'h0900, 16'h0A00, 16'h2, 16'h159);
    await_done();
    chk({31'h0, irq}, 32'h1);
    chk({16'h0, u_dma_memory_model.mem[0]}, {16'h0, w0});
    chk({16'h0, u_dma_memory_model.mem[1]}, {16'h0, ~w0});
    rd(ch(0, 5'h08), 32'h0904);
    rd(ch(0, 5'h10), 32'h0);
    rd(ch(0, 5'h00), 32'h058);
    apb(1'b1, 12'h018, 32'h0);
    rd(12'h010, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h014, 32'h3F);
    apb(1'b1, 12'h018, 32'h3F);
    rd(12'h010, 32'h0, 32'h3F);
    chk({31'h0, irq}, 32'h0);
    $display("test software word burst done");
    code = 7'($random(seed)) | 7'h01;
    apb(1'b1, ch(1, 5'h04), {17'h0, code, 8'h00});
    rd(ch(1, 5'h04), {17'h0, code, 8'h00}, 32'h7F00);
    prog(1, 16'h0901, 16'h0A10, 16'h1, 16'h087);
    trigger_in[code] <= 1'b1;
    @(posedge core_clk);
    trigger_in[code] <= 1'b0;
    await_done();
    chk({24'h0, u_dma_memory_model.mem[8][7:0]}, {24'h0, w0[15:8]});
    rd(ch(1, 5'h08), 32'h0901);
    rd(ch(1, 5'h10), 32'h1);
    rd(ch(1, 5'h00), 32'h087);
    apb(1'b1, 12'h000, 32'h0);
    trigger_in[code] <= 1'b1;
    @(posedge core_clk);
    trigger_in[code] <= 1'b0;
    busy = 0;
    repeat (12) @(posedge core_clk) busy += mem_req;
    chk(32'(busy), 32'h0);
    apb(1'b1, 12'h000, 32'h8000);
    $display("test trigger byte repeat done");
    u_dma_memory_model.mem[8'h82] = ~w0;
    prog(3, 16'h0900, 16'h0A0A, 16'h2, 16'h129);
    apb(1'b1, ch(0, 5'h00), 32'h101);
    await_done();
    chk({16'h0, u_dma_memory_model.mem[5]}, {16'h0, w0});
    chk({16'h0, u_dma_memory_model.mem[4]}, {16'h0, w0});
    chk({16'h0, u_dma_memory_model.mem[2]}, {16'h0, ~w0});
    rd(ch(3, 5'h08), 32'h0900);
    rd(ch(3, 5'h0C), 32'h0A06);
    rd(ch(0, 5'h00), 32'h001);
    apb(1'b1, 12'h014, 32'h3F);
    rd(12'h010, 32'h0, 32'h3F);
    chk({31'h0, irq}, 32'h0);
    $display("test hold and priority done");
    apb(1'b1, 12'h004, 32'h0A00);
    apb(1'b1, 12'h008, 32'h0900);
    u_dma_memory_model.mem[8'hA0] = 16'h0000;
    prog(2, 16'h0900, 16'h0B40, 16'h1, 16'h151);
    await_done();
    chk({31'h0, irq}, 32'h1);
    rd(ch(2, 5'h04), 32'h80, 32'h80);
    chk({16'h0, u_dma_memory_model.mem[8'hA0]}, 32'h0);
    $display("test limit violation done");
    tally_and_finish();
  end
endmodule
